// File: dics_pkg.sv
// constants and types shared by the conversion sequencer
package dics_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CLEAR_TIME_NS = 400;
  localparam int CHANNELS      = 16;
  localparam int GROUPS        = 4;
  localparam int WORD_W        = 16;
  localparam int ACC_W         = 17;
  localparam int FRAME_W       = CHANNELS * WORD_W;

  localparam logic [1:0] GRP_LAST  = 2'h3;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [3:0] WORD_LAST = 4'hf;

  localparam logic [15:0] ZERO_CODE = 16'h0492;
  localparam logic [15:0] FULL_CODE = 16'hffff;
  localparam logic [15:0] MASK_14   = 16'hfffc;
  localparam logic [15:0] MASK_12   = 16'hfff0;

  localparam logic [1:0] LEN_SEL_16 = 2'h0;
  localparam logic [1:0] LEN_SEL_14 = 2'h1;
  localparam logic [3:0] LAST_BIT_16 = 4'hf;
  localparam logic [3:0] LAST_BIT_14 = 4'hd;
  localparam logic [3:0] LAST_BIT_12 = 4'hb;

  localparam logic [1:0] RANGE_SMALL = 2'h0;
  localparam logic [1:0] RANGE_MID   = 2'h1;
  localparam logic [2:0] CAP_SMALL   = 3'h1;
  localparam logic [2:0] CAP_MID     = 3'h2;
  localparam logic [2:0] CAP_LARGE   = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_INTEGRATION_SIDE_SELECT    = 3'h1,
    ST_COLLECT = 3'h3,
    ST_PUSH    = 3'h2,
    ST_CLEAR   = 3'h6,
    ST_PARK    = 3'h4
  } dics_state_type;
endpackage

// File: dics_pair_buffer.sv
// two-entry valid/ready buffer for result words
`timescale 1ns/1ps
module dics_pair_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] memReg [DEPTH];
  logic             wrPtrReg;
  logic             rdPtrReg;
  logic [1:0]       countReg;
  logic             doWrite;
  logic             doRead;

  if (DEPTH != 2 || WIDTH < 1) begin : g_check
    $error("pair buffer holds exactly two entries");
  end

  assign inReady  = (countReg != 2'h2);
  assign outValid = (countReg != 2'h0);
  assign outData  = memReg[rdPtrReg];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      memReg[wrPtrReg] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtrReg <= 1'b0;
      rdPtrReg <= 1'b0;
      countReg <= 2'h0;
    end else begin
      if (doWrite) begin
        wrPtrReg <= ~wrPtrReg;
      end
      if (doRead) begin
        rdPtrReg <= ~rdPtrReg;
      end
      if (doWrite && !doRead) begin
        countReg <= countReg + 2'h1;
      end else if (doRead && !doWrite) begin
        countReg <= countReg - 2'h1;
      end
    end
  end
endmodule

// File: dics_sequencer.sv
// integrator sequencing, result formatting and serial output
`timescale 1ns/1ps
module dics_sequencer #(
  parameter int CLEAR_NS = dics_pkg::CLEAR_TIME_NS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        integration_side_select,
  input  wire logic [1:0]  word_length_select,
  input  wire logic [1:0]  rangeSelect,
  output logic      [15:0] side_a_input_switch,
  output logic      [15:0] side_b_input_switch,
  output logic      [1:0]  reference_connect_switch,
  output logic      [1:0]  capacitor_clear_switch,
  output logic      [2:0]  capacitorSelect,
  output logic             convStart,
  output logic             convSide,
  output logic      [1:0]  convSlot,
  input  wire logic        convDone,
  input  wire logic [67:0] convResult,
  output logic             result_ready_n,
  input  wire logic        serial_clk,
  output logic             serialOut
);
  localparam int CLEAR_CYC =
    (CLEAR_NS + dics_pkg::CLK_PERIOD_NS - 1) / dics_pkg::CLK_PERIOD_NS;
  localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_CYC - 1);

  if (CLEAR_CYC < 1 || CLEAR_CYC > 256) begin : g_check
    $error("clear time must fit 1 to 256 cycles");
  end

  logic                          phaseMetaReg;
  logic                          phaseSyncReg;
  logic                          phaseDlyReg;
  logic [1:0]                    lenMetaReg;
  logic [1:0]                    lenSyncReg;
  logic [1:0]                    rangeMetaReg;
  logic [1:0]                    rangeSyncReg;
  logic                          phaseEdge;
  logic                          launch;
  logic                          pendingReg;
  dics_pkg::dics_state_type      stateReg;
  logic [1:0]                    slotReg;
  logic [1:0]                    grpReg;
  logic [7:0]                    clearCntReg;
  logic                          convSideReg;
  logic [1:0]                    swReg;
  logic [15:0]                   sideAReg;
  logic [15:0]                   sideBReg;
  logic [2:0]                    capReg;
  logic signed [16:0]            accGroup [dics_pkg::GROUPS];
  logic signed [16:0]            holdReg [dics_pkg::GROUPS];
  logic signed [16:0]            holdSel;
  logic signed [17:0]            sumSel;
  logic [15:0]                   wordSel;
  logic                          bufInValid;
  logic                          bufInReady;
  logic [15:0]                   bufInData;
  logic                          bufOutValid;
  logic                          bufOutReady;
  logic [15:0]                   bufOutData;
  logic [dics_pkg::FRAME_W-1:0]  frameReg;
  logic [3:0]                    wordCntReg;
  logic                          fullReg;
  logic                          readyNReg;
  logic [3:0]                    lastBitReg;
  logic                          doneMetaReg;
  logic                          doneSyncReg;
  logic                          doneDlyReg;
  logic                          doneEdge;
  logic                          lrstMetaReg;
  logic                          lrstSyncReg;
  logic [3:0]                    bitIdxReg;
  logic [3:0]                    wordIdxReg;
  logic                          doneTglReg;
  logic                          serialOutReg;

  // pins are asynchronous to core_clk: two flops before any use
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      phaseMetaReg <= 1'b0;
      phaseSyncReg <= 1'b0;
      phaseDlyReg  <= 1'b0;
    end else begin
      phaseMetaReg <= integration_side_select;
      phaseSyncReg <= phaseMetaReg;
      phaseDlyReg  <= phaseSyncReg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lenMetaReg   <= dics_pkg::LEN_SEL_16;
      lenSyncReg   <= dics_pkg::LEN_SEL_16;
      rangeMetaReg <= dics_pkg::RANGE_SMALL;
      rangeSyncReg <= dics_pkg::RANGE_SMALL;
    end else begin
      lenMetaReg   <= word_length_select;
      lenSyncReg   <= lenMetaReg;
      rangeMetaReg <= rangeSelect;
      rangeSyncReg <= rangeMetaReg;
    end
  end

  assign phaseEdge = phaseSyncReg ^ phaseDlyReg;

  // low phase means side B collects, so B is the reset state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sideAReg <= '0;
      sideBReg <= '1;
    end else begin
      sideAReg <= {dics_pkg::CHANNELS{phaseSyncReg}};
      sideBReg <= {dics_pkg::CHANNELS{~phaseSyncReg}};
    end
  end

  // the two switch sets are exact complements, charge is never lost
  assign side_a_input_switch = sideAReg;
  assign side_b_input_switch = sideBReg;

  // one capacitor code drives every integrator of both sides
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      capReg <= dics_pkg::CAP_SMALL;
    end else begin
      case (rangeSyncReg)
        dics_pkg::RANGE_SMALL: capReg <= dics_pkg::CAP_SMALL;
        dics_pkg::RANGE_MID:   capReg <= dics_pkg::CAP_MID;
        default:               capReg <= dics_pkg::CAP_LARGE;
      endcase
    end
  end

  assign capacitorSelect = capReg;

  // an edge during a busy sequence is kept and served at park
  assign launch = ((stateReg == dics_pkg::ST_IDLE) || (stateReg == dics_pkg::ST_PARK))
                  && (phaseEdge || pendingReg);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pendingReg <= 1'b0;
    end else if (launch) begin
      pendingReg <= 1'b0;
    end else if (phaseEdge) begin
      pendingReg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg    <= dics_pkg::ST_IDLE;
      slotReg     <= 2'h0;
      grpReg      <= 2'h0;
      clearCntReg <= 8'h00;
      convSideReg <= 1'b0;
      swReg       <= 2'h0;
    end else begin
      case (stateReg)
        dics_pkg::ST_IDLE, dics_pkg::ST_PARK: begin
          if (launch) begin
            stateReg    <= dics_pkg::ST_INTEGRATION_SIDE_SELECT;
            slotReg     <= 2'h0;
            convSideReg <= phaseSyncReg;
          end
        end
        dics_pkg::ST_INTEGRATION_SIDE_SELECT: begin
          stateReg <= dics_pkg::ST_COLLECT;
        end
        dics_pkg::ST_COLLECT: begin
          if (convDone) begin
            stateReg <= dics_pkg::ST_PUSH;
            grpReg   <= 2'h0;
          end
        end
        dics_pkg::ST_PUSH: begin
          if (bufInReady) begin
            grpReg <= grpReg + 2'h1;
            if (grpReg == dics_pkg::GRP_LAST) begin
              if (slotReg == dics_pkg::SLOT_LAST) begin
                stateReg    <= dics_pkg::ST_CLEAR;
                clearCntReg <= 8'h00;
                swReg       <= {convSideReg, ~convSideReg};
              end else begin
                slotReg  <= slotReg + 2'h1;
                stateReg <= dics_pkg::ST_INTEGRATION_SIDE_SELECT;
              end
            end
          end
        end
        dics_pkg::ST_CLEAR: begin
          if (clearCntReg == CLEAR_LAST) begin
            stateReg <= dics_pkg::ST_PARK;
            swReg    <= 2'h0;
          end else begin
            clearCntReg <= clearCntReg + 8'h01;
          end
        end
        default: begin
          stateReg <= dics_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign reference_connect_switch = swReg;
  assign capacitor_clear_switch   = swReg;
  assign convStart = (stateReg == dics_pkg::ST_INTEGRATION_SIDE_SELECT);
  assign convSide  = convSideReg;
  assign convSlot  = slotReg;

  for (genvar g = 0; g < dics_pkg::GROUPS; g++) begin : g_grp
    assign accGroup[g] = convResult[g*dics_pkg::ACC_W +: dics_pkg::ACC_W];
    always_ff @(posedge core_clk) begin
      if (stateReg == dics_pkg::ST_COLLECT && convDone) begin
        holdReg[g] <= accGroup[g];
      end
    end
  end

  // converter count is relative to zero input; the offset keeps leakage on scale
  assign holdSel = holdReg[grpReg];
  assign sumSel  = 18'(holdSel) + $signed({2'h0, dics_pkg::ZERO_CODE});

  always_comb begin
    if (sumSel < 0) begin
      wordSel = '0;
    end else if (sumSel > $signed({2'h0, dics_pkg::FULL_CODE})) begin
      wordSel = dics_pkg::FULL_CODE;
    end else begin
      wordSel = sumSel[15:0];
    end
  end

  always_comb begin
    case (lenSyncReg)
      dics_pkg::LEN_SEL_16: bufInData = wordSel;
      dics_pkg::LEN_SEL_14: bufInData = wordSel & dics_pkg::MASK_14;
      default:              bufInData = wordSel & dics_pkg::MASK_12;
    endcase
  end

  // a full buffer holds the sequencer in push, so no word is dropped
  assign bufInValid = (stateReg == dics_pkg::ST_PUSH);

  dics_pair_buffer #(
    .WIDTH (dics_pkg::WORD_W),
    .DEPTH (2)
  ) u_buffer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // frame is frozen while ready is low; the link reads it without copying
  assign bufOutReady = ~fullReg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frameReg   <= '0;
      wordCntReg <= 4'h0;
      fullReg    <= 1'b0;
      readyNReg  <= 1'b1;
      lastBitReg <= dics_pkg::LAST_BIT_16;
    end else if (doneEdge) begin
      fullReg    <= 1'b0;
      readyNReg  <= 1'b1;
      wordCntReg <= 4'h0;
    end else if (bufOutValid && !fullReg) begin
      frameReg   <= {frameReg[dics_pkg::FRAME_W-dics_pkg::WORD_W-1:0], bufOutData};
      wordCntReg <= wordCntReg + 4'h1;
      if (wordCntReg == dics_pkg::WORD_LAST) begin
        fullReg   <= 1'b1;
        readyNReg <= 1'b0;
        case (lenSyncReg)
          dics_pkg::LEN_SEL_16: lastBitReg <= dics_pkg::LAST_BIT_16;
          dics_pkg::LEN_SEL_14: lastBitReg <= dics_pkg::LAST_BIT_14;
          default:              lastBitReg <= dics_pkg::LAST_BIT_12;
        endcase
      end
    end
  end

  assign result_ready_n = readyNReg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      doneMetaReg <= 1'b0;
      doneSyncReg <= 1'b0;
      doneDlyReg  <= 1'b0;
    end else begin
      doneMetaReg <= doneTglReg;
      doneSyncReg <= doneMetaReg;
      doneDlyReg  <= doneSyncReg;
    end
  end

  assign doneEdge = doneSyncReg ^ doneDlyReg;

  // link side: runs only while the controller clocks data out
  always_ff @(posedge serial_clk) begin
    lrstMetaReg <= sys_rst;
    lrstSyncReg <= lrstMetaReg;
  end

  always_ff @(posedge serial_clk) begin
    if (lrstSyncReg) begin
      bitIdxReg    <= 4'h0;
      wordIdxReg   <= 4'h0;
      doneTglReg   <= 1'b0;
      serialOutReg <= 1'b0;
    end else begin
      serialOutReg <= frameReg[{~wordIdxReg, ~bitIdxReg}];
      if (bitIdxReg == lastBitReg) begin
        bitIdxReg  <= 4'h0;
        wordIdxReg <= wordIdxReg + 4'h1;
        if (wordIdxReg == dics_pkg::WORD_LAST) begin
          doneTglReg <= ~doneTglReg;
        end
      end else begin
        bitIdxReg <= bitIdxReg + 4'h1;
      end
    end
  end

  assign serialOut = serialOutReg;

  sequence s_rise;
    phaseSyncReg && !phaseDlyReg;
  endsequence

  sequence s_fall;
    !phaseSyncReg && phaseDlyReg;
  endsequence

  property p_side_a_on_rise;
    @(posedge core_clk) disable iff (sys_rst)
    s_rise |=> (side_a_input_switch == '1) && (side_b_input_switch == '0);
  endproperty
  a_side_a_on_rise: assert property (p_side_a_on_rise)
    else $error("side A not closed after phase rise");

  property p_side_b_on_fall;
    @(posedge core_clk) disable iff (sys_rst)
    s_fall |=> (side_b_input_switch == '1) && (side_a_input_switch == '0);
  endproperty
  a_side_b_on_fall: assert property (p_side_b_on_fall)
    else $error("side B not closed after phase fall");

  property p_held_side;
    @(posedge core_clk) disable iff (sys_rst)
    launch |=> convStart && (convSide == $past(phaseSyncReg)) && (convSlot == 2'h0);
  endproperty
  a_held_side: assert property (p_held_side)
    else $error("wrong side presented to converter");

  property p_continuous;
    @(posedge core_clk) disable iff (sys_rst)
    side_a_input_switch == ~side_b_input_switch;
  endproperty
  a_continuous: assert property (p_continuous)
    else $error("both sides or neither side integrating");

  property p_clear_after_group;
    @(posedge core_clk) disable iff (sys_rst)
    $rose(|capacitor_clear_switch) |-> $past(slotReg) == dics_pkg::SLOT_LAST
      && $past(grpReg) == dics_pkg::GRP_LAST && $past(bufInReady);
  endproperty
  a_clear_after_group: assert property (p_clear_after_group)
    else $error("capacitor cleared before group finished");

  property p_ref_release;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(|reference_connect_switch) |-> (stateReg == dics_pkg::ST_PARK)
      && (capacitor_clear_switch == 2'h0) && $past(clearCntReg) == CLEAR_LAST;
  endproperty
  a_ref_release: assert property (p_ref_release)
    else $error("reference released at wrong time");

  property p_ready_on_full;
    @(posedge core_clk) disable iff (sys_rst)
    $fell(result_ready_n) |-> $past(wordCntReg) == dics_pkg::WORD_LAST && $past(bufOutValid);
  endproperty
  a_ready_on_full: assert property (p_ready_on_full)
    else $error("ready asserted without a full frame");

  property p_ready_holds;
    @(posedge core_clk) disable iff (sys_rst)
    !result_ready_n && !doneEdge |=> !result_ready_n ##0 $stable(frameReg);
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready or frame changed before retrieval");

  property p_range_top;
    @(posedge core_clk) disable iff (sys_rst)
    rangeSyncReg == 2'h3 |=> capacitorSelect == dics_pkg::CAP_LARGE;
  endproperty
  a_range_top: assert property (p_range_top)
    else $error("range 11 not mapped to largest capacitor");

  property p_zero_code;
    @(posedge core_clk) disable iff (sys_rst)
    bufInValid && holdSel == 17'sh0 && lenSyncReg == dics_pkg::LEN_SEL_16
      |-> bufInData == dics_pkg::ZERO_CODE;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("zero input not at offset code");

  property p_saturate;
    @(posedge core_clk) disable iff (sys_rst)
    bufInValid && sumSel < 0 |-> bufInData == '0;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("negative overrange not clipped to zero");

  property p_truncate;
    @(posedge core_clk) disable iff (sys_rst)
    bufInValid && lenSyncReg[1] |-> bufInData[3:0] == 4'h0;
  endproperty
  a_truncate: assert property (p_truncate)
    else $error("12-bit word keeps low bits");
endmodule

// File: dics_far_model.sv
// converter model on the far side of the sequencer's conversion port
`timescale 1ns/1ps
module dics_far_model (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               convStart,
  input  wire logic [1:0]         convSlot,
  input  wire logic signed [16:0] countBase,
  input  wire logic signed [16:0] countStep,
  input  wire logic [3:0]         lagCycles,
  output logic                    convDone,
  output logic      [67:0]        convResult
);
  logic       busyReg;
  logic [3:0] waitReg;
  logic [1:0] slotReg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busyReg    <= 1'b0;
      waitReg    <= 4'h0;
      slotReg    <= 2'h0;
      convDone   <= 1'b0;
      convResult <= '0;
    end else begin
      convDone   <= 1'b0;
      // results are only good in the done cycle, so flip them elsewhere
      convResult <= ~convResult;
      if (convStart) begin
        busyReg <= 1'b1;
        waitReg <= lagCycles;
        slotReg <= convSlot;
      end else if (busyReg && waitReg == 4'h0) begin
        busyReg  <= 1'b0;
        convDone <= 1'b1;
        for (int g = 0; g < 4; g++) begin
          convResult[g*17+:17] <= 17'(int'(countBase)
                                  + int'(countStep) * (int'(slotReg) * 4 + g));
        end
      end else if (busyReg) begin
        waitReg <= waitReg - 4'h1;
      end
    end
  end
endmodule

// File: tb_dual_integrator_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_dual_integrator_conversion_sequencer;
  typedef struct {
    logic [1:0]         len;
    logic [1:0]         rng;
    logic signed [16:0] base;
    logic signed [16:0] step;
    logic [3:0]         lag;
    logic [2:0]         cap;
  } dics_row_type;

  logic               coreClk = 1'b0;
  logic               sysRst = 1'b1;
  logic               phase = 1'b0;
  logic [1:0]         lenSel = 2'h0;
  logic [1:0]         rngSel = 2'h0;
  logic               serialClk = 1'b0;
  logic signed [16:0] countBase = '0;
  logic signed [16:0] countStep = '0;
  logic [3:0]         lagCycles = 4'h0;
  logic [15:0]        sideA;
  logic [15:0]        sideB;
  logic [1:0]         refSw;
  logic [1:0]         clrSw;
  logic [2:0]         capSel;
  logic               convStart;
  logic               convSide;
  logic [1:0]         convSlot;
  logic               convDone;
  logic [67:0]        convResult;
  logic               readyN;
  logic               serialOut;
  int                 num_errors = 0;
  int                 checks = 0;

  dics_row_type rows [4] = '{
    '{2'h0, 2'h0, 17'sh0,    17'sh1,   4'h0, 3'h1},
    '{2'h1, 2'h1, -17'sh4a0, 17'sh40,  4'h2, 3'h2},
    '{2'h2, 2'h2, 17'shfb00, 17'sh40,  4'h9, 3'h4},
    '{2'h3, 2'h3, 17'sh100,  17'sh333, 4'h1, 3'h4}
  };

  always #20 coreClk = ~coreClk;

  dics_sequencer u_dics_sequencer (
    .core_clk                (coreClk),
    .sys_rst                 (sysRst),
    .integration_side_select (phase),
    .word_length_select      (lenSel),
    .rangeSelect             (rngSel),
    .side_a_input_switch     (sideA),
    .side_b_input_switch     (sideB),
    .reference_connect_switch(refSw),
    .capacitor_clear_switch  (clrSw),
    .capacitorSelect         (capSel),
    .convStart               (convStart),
    .convSide                (convSide),
    .convSlot                (convSlot),
    .convDone                (convDone),
    .convResult              (convResult),
    .result_ready_n          (readyN),
    .serial_clk              (serialClk),
    .serialOut               (serialOut)
  );

  dics_far_model u_dics_far_model (
    .core_clk  (coreClk),
    .sys_rst   (sysRst),
    .convStart (convStart),
    .convSlot  (convSlot),
    .countBase (countBase),
    .countStep (countStep),
    .lagCycles (lagCycles),
    .convDone  (convDone),
    .convResult(convResult)
  );

  task automatic tick();
    @(posedge coreClk);
    #1;
  endtask

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [15:0] expWord(input dics_row_type r, input int ch);
    int v;
    v = int'(r.base) + int'(r.step) * ch + int'(dics_pkg::ZERO_CODE);
    if (v < 0) v = 0;
    if (v > 'hffff) v = 'hffff;
    expWord = 16'(v);
    if (r.len == dics_pkg::LEN_SEL_14) expWord &= dics_pkg::MASK_14;
    else if (r.len != dics_pkg::LEN_SEL_16) expWord &= dics_pkg::MASK_12;
  endfunction

  task automatic runCase(input dics_row_type r, input bit stall);
    int n;
    int bits;
    logic [15:0] word;
    bits = (r.len == 2'h0) ? 16 : (r.len == 2'h1) ? 14 : 12;
    @(posedge coreClk);
    lenSel    <= r.len;
    rngSel    <= r.rng;
    countBase <= r.base;
    countStep <= r.step;
    lagCycles <= r.lag;
    phase     <= ~phase;
    tick();
    for (n = 0; n < 8 && convStart !== 1'b1; n++) tick();
    check("convStart", 1'b1, convStart);
    check("side switches", {{16{phase}}, {16{~phase}}}, {sideA, sideB});
    check("integration_side_select side slot", {phase, 2'h0}, {convSide, convSlot});
    for (n = 0; n < 600 && refSw === 2'h0; n++) tick();
    check("reference switch", phase ? 2'h2 : 2'h1, refSw);
    check("clear switch", phase ? 2'h2 : 2'h1, clrSw);
    check("capacitor", r.cap, capSel);
    for (n = 0; n < 50 && refSw !== 2'h0; n++) tick();
    check("clear cycles", dics_pkg::CLEAR_TIME_NS / dics_pkg::CLK_PERIOD_NS, n);
    check("parked switches", 4'h0, {refSw, clrSw});
    for (n = 0; n < 100 && readyN !== 1'b0; n++) tick();
    check("ready low", 1'b0, readyN);
    // link clock only runs inside the frame and is offset from the core clock
    #13;
    for (int w = 0; w < 16; w++) begin
      word = '0;
      for (int b = 0; b < bits; b++) begin
        #40 serialClk = 1'b1;
        #40 serialClk = 1'b0;
        word[15-b] = serialOut;
      end
      check("serial word", expWord(r, w), word);
      if (stall && w == 7) #2000;
    end
    for (n = 0; n < 20 && readyN !== 1'b1; n++) tick();
    check("ready released", 1'b1, readyN);
    $display("test done: length %h range %h stall %0d", r.len, r.rng, stall);
  endtask

  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    give_verdict();
  end

  initial begin
    // link logic needs several link edges inside reset, so reset outlasts 3 cycles
    repeat (3) @(posedge coreClk);
    for (int i = 0; i < 4; i++) begin
      #40 serialClk = 1'b1;
      #40 serialClk = 1'b0;
    end
    @(posedge coreClk);
    sysRst <= 1'b0;
    // the link lets go of reset only after two link edges of its own
    for (int i = 0; i < 2; i++) begin
      #40 serialClk = 1'b1;
      #40 serialClk = 1'b0;
    end
    tick();
    check("reset state", {sideA, sideB, refSw, clrSw, capSel, readyN, serialOut},
          {16'h0, 16'hffff, 2'h0, 2'h0, 3'h1, 1'b1, 1'b0});
    $display("test done: reset");
    for (int i = 0; i < 4; i++) runCase(rows[i], 1'b0);
    // boundary codes on both rails, slow converter and a stalled reader
    runCase('{2'h0, 2'h3, -17'sh492, 17'sh1111, 4'hf, 3'h4}, 1'b1);
    give_verdict();
  end
endmodule
